// ---- ins_defs.svh ----
// Constants for the interrupt and non-maskable request front end
`ifndef INS_DEFS_SVH
`define INS_DEFS_SVH
`define INS_SYNC_STAGES 2
`define INS_DEAD_CLOCKS 2
`define INS_DEAD_CNT_W 2
`define INS_DEAD_ZERO 2'h0
`define INS_DEAD_ONE 2'h1
`endif

// ---- ins_pkg.sv ----
// Types for the interrupt and non-maskable request front end
package ins_pkg;
  typedef enum logic [1:0] {
    INS_RUN   = 2'h0,
    INS_DEAD  = 2'h1,
    INS_START = 2'h3
  } ins_state_e;
  typedef enum logic {
    INS_SRC_MASKABLE = 1'h0,
    INS_SRC_NMI      = 1'h1
  } ins_src_e;
endpackage

// ---- ins_sync2.sv ----
// Two-flop synchroniser for one asynchronous request pin
`timescale 1ns/10ps
module ins_sync2 (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic clkEn,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic metaReg;
  logic syncReg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      metaReg <= 1'h0;
      syncReg <= 1'h0;
    end else if (clkEn) begin
      metaReg <= asyncIn;
      syncReg <= metaReg;
    end
  end

  assign syncOut = syncReg;
endmodule

// ---- ins_nmi_latch.sv ----
// Non-maskable edge detect, latch, in-service mask and single pending slot
`timescale 1ns/10ps
module ins_nmi_latch (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic clkEn,
  input  wire logic nmiSync,
  input  wire logic nmiTaken,
  input  wire logic retDone,
  output logic      nmiPending,
  output logic      nmiMasked
);
  logic prevReg;
  logic pendReg;
  logic pendNext;
  logic maskReg;
  logic maskNext;
  logic riseEdge;

  // Level must fall and stay low to re-arm
  assign riseEdge = nmiSync & ~prevReg;
  // Edge wins over the taken clear; one slot only, extra edges merge
  assign pendNext = riseEdge | (pendReg & ~nmiTaken);
  // Mask set on entry, cleared by the return instruction
  assign maskNext = nmiTaken | (maskReg & ~retDone);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prevReg <= 1'h0;
      pendReg <= 1'h0;
      maskReg <= 1'h0;
    end else if (clkEn) begin
      prevReg <= nmiSync;
      pendReg <= pendNext;
      maskReg <= maskNext;
    end
  end

  assign nmiPending = pendReg;
  assign nmiMasked  = maskReg;
endmodule

// ---- ins_front_end.sv ----
// Interrupt front end between request pins and the execution unit
`timescale 1ns/10ps
`include "ins_defs.svh"
// How it works
// - Maskable pin passes only two sync flops
// - Maskable is a level; withdrawn request ignored
// - Sample only at instruction or string boundaries
// - Late request caught at next boundary
// - Service starts after two dead clocks
// - Latency bounded: instruction plus five clocks from the pin
// - Non-maskable pin uses same sync
// - Non-maskable triggers on rising edge
// - Short or long pulse latched once
// - Non-maskable masked until return instruction
// - One further non-maskable held pending
module ins_front_end (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic clkEn,
  input  wire logic maskable_irq_in,
  input  wire logic nmiIn,
  input  wire logic intEnable,
  input  wire logic instrBoundary,
  input  wire logic interrupt_return_instr,
  output logic      holdNextInstr,
  output logic      serviceStart,
  output logic      serviceIsNmi,
  output logic      nmiMaskedOut
);
  logic                          intrSync;
  logic                          nmiSync;
  logic                          nmiPending;
  logic                          nmiMasked;
  logic                          nmiReady;
  logic                          intrReady;
  logic                          acceptNow;
  logic                          acceptNmi;
  logic                          nmiTaken;
  ins_pkg::ins_state_e           state_reg;
  ins_pkg::ins_state_e           state_next;
  logic [`INS_DEAD_CNT_W-1:0]    deadCnt_reg;
  logic [`INS_DEAD_CNT_W-1:0]    deadCnt_next;
  ins_pkg::ins_src_e             src_reg;
  logic                          hold_reg;
  logic                          start_reg;
  logic                          isNmi_reg;
  logic                          maskOut_reg;

  ins_sync2 u_intrSync (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .clkEn   (clkEn),
    .asyncIn (maskable_irq_in),
    .syncOut (intrSync)
  );

  ins_sync2 u_nmiSync (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .clkEn   (clkEn),
    .asyncIn (nmiIn),
    .syncOut (nmiSync)
  );

  ins_nmi_latch u_nmiLatch (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .clkEn      (clkEn),
    .nmiSync    (nmiSync),
    .nmiTaken   (nmiTaken),
    .retDone    (interrupt_return_instr),
    .nmiPending (nmiPending),
    .nmiMasked  (nmiMasked)
  );

  // A pending edge waits out the handler, then is served
  assign nmiReady  = nmiPending & ~nmiMasked;
  // Live level only; a dropped request is never latched
  assign intrReady = intrSync & intEnable;
  assign acceptNow = (state_reg == ins_pkg::INS_RUN) & instrBoundary
                     & (nmiReady | intrReady);
  assign acceptNmi = nmiReady;
  assign nmiTaken  = acceptNow & acceptNmi;

  always_comb begin
    state_next   = state_reg;
    deadCnt_next = deadCnt_reg;
    unique case (state_reg)
      ins_pkg::INS_RUN: begin
        if (acceptNow) begin
          state_next   = ins_pkg::INS_DEAD;
          deadCnt_next = `INS_DEAD_ZERO;
        end
      end
      ins_pkg::INS_DEAD: begin
        // Count the dead clocks before vectoring
        deadCnt_next = deadCnt_reg + `INS_DEAD_ONE;
        if (deadCnt_reg == `INS_DEAD_CNT_W'(`INS_DEAD_CLOCKS - 1)) begin
          state_next = ins_pkg::INS_START;
        end
      end
      ins_pkg::INS_START: begin
        state_next = ins_pkg::INS_RUN;
      end
      default: begin
        state_next = ins_pkg::INS_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg   <= ins_pkg::INS_RUN;
      deadCnt_reg <= `INS_DEAD_ZERO;
      src_reg     <= ins_pkg::INS_SRC_MASKABLE;
    end else if (clkEn) begin
      state_reg   <= state_next;
      deadCnt_reg <= deadCnt_next;
      if (acceptNow) begin
        src_reg <= acceptNmi ? ins_pkg::INS_SRC_NMI : ins_pkg::INS_SRC_MASKABLE;
      end
    end
  end

  // Registered outputs; holdNextInstr blocks the next instruction
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hold_reg    <= 1'h0;
      start_reg   <= 1'h0;
      isNmi_reg   <= 1'h0;
      maskOut_reg <= 1'h0;
    end else if (clkEn) begin
      hold_reg    <= (state_next != ins_pkg::INS_RUN);
      start_reg   <= (state_next == ins_pkg::INS_START);
      isNmi_reg   <= (state_next == ins_pkg::INS_START) & (src_reg == ins_pkg::INS_SRC_NMI);
      maskOut_reg <= nmiMasked;
    end
  end

  assign holdNextInstr = hold_reg;
  assign serviceStart  = start_reg;
  assign serviceIsNmi  = isNmi_reg;
  assign nmiMaskedOut  = maskOut_reg;
endmodule

// ---- ins_front_end_checker.sv ----
// Port assertions for the interrupt front end
`timescale 1ns/10ps
module ins_front_end_checker (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic intEnable,
  input wire logic instrBoundary,
  input wire logic interrupt_return_instr,
  input wire logic holdNextInstr,
  input wire logic serviceStart,
  input wire logic serviceIsNmi,
  input wire logic nmiMaskedOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence seqHold; holdNextInstr[*3] ##1 !holdNextInstr; endsequence
  sequence seqDead; !serviceStart[*2] ##1 serviceStart; endsequence
  chk_hold_len: assert property ($rose(holdNextInstr) |-> seqHold) else $error("hold length");
  chk_dead_clocks: assert property ($rose(holdNextInstr) |-> seqDead) else $error("dead clocks");
  chk_start_pulse: assert property (serviceStart |=> !serviceStart) else $error("start pulse");
  chk_nmi_flag: assert property (serviceIsNmi |-> serviceStart) else $error("nmi flag");
  chk_at_boundary: assert property (serviceStart |-> $past(instrBoundary, 3)) else $error("boundary");
  chk_int_enable: assert property (serviceStart && !serviceIsNmi |-> $past(intEnable, 3)) else $error("enable");
  chk_mask_entry: assert property (serviceStart && serviceIsNmi |-> nmiMaskedOut) else $error("mask entry");
  chk_mask_ret: assert property ($fell(nmiMaskedOut) |-> $past(interrupt_return_instr, 2)) else $error("unmask");
  chk_freeze_out: assert property (!clkEn |=> $stable(holdNextInstr) && $stable(serviceStart) && $stable(nmiMaskedOut)) else $error("freeze");
endmodule

// ---- ins_irq_src.sv ----
// Request source model driving both request pins
`timescale 1ns/10ps
module ins_irq_src (
  input  wire logic mclk,
  input  wire logic holdNextInstr,
  input  wire logic serviceStart,
  input  wire logic serviceIsNmi,
  output logic      maskable_irq_in,
  output logic      nmiIn
);
  logic want     = 1'b0;
  logic holdSeen = 1'b0;
  initial maskable_irq_in = 1'b0;
  initial nmiIn = 1'b0;
  // Drop at accept: dropping at service start leaves the sync high into the next boundary
  // An accepted non-maskable service did not answer the level, so it comes back
  always @(posedge mclk) begin
    holdSeen <= holdNextInstr;
    if (holdNextInstr && !holdSeen) maskable_irq_in <= 1'b0;
    if (serviceStart && serviceIsNmi && want) maskable_irq_in <= 1'b1;
    if (serviceStart && !serviceIsNmi) want <= 1'b0;
  end
  task automatic set_maskable_irq_in(input logic v);
    @(posedge mclk) begin
      maskable_irq_in <= v;
      want            <= v;
    end
  endtask
  task automatic nmi_pulse(input int len);
    @(posedge mclk) nmiIn <= 1'b1;
    repeat (len) @(posedge mclk);
    nmiIn <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
endmodule

// ---- tb_ins_front_end.sv ----
// Bench for the interrupt front end
`timescale 1ns/10ps
`include "ins_defs.svh"
module tb_ins_front_end;
  logic mclk = 1'b0, arst_n = 1'b0, intEn = 1'b0, bnd = 1'b0, ret = 1'b0, bEn = 1'b1, ce = 1'b1;
  logic irq, nmi, hold, start, isNmi, masked;
  int   mismatches = 0, check_count = 0, nS = 0, nN = 0, cyc = 0, gap = 1;
  always #2 mclk = ~mclk;
  ins_front_end DUT (.mclk(mclk), .arst_n(arst_n), .clkEn(ce), .maskable_irq_in(irq), .nmiIn(nmi),
    .intEnable(intEn), .instrBoundary(bnd), .interrupt_return_instr(ret), .holdNextInstr(hold),
    .serviceStart(start), .serviceIsNmi(isNmi), .nmiMaskedOut(masked));
  ins_irq_src SRC (.mclk(mclk), .holdNextInstr(hold), .serviceStart(start), .serviceIsNmi(isNmi),
    .maskable_irq_in(irq), .nmiIn(nmi));
  // Longest instruction is eight clocks
  function automatic int lat_max();
    return 8 + `INS_SYNC_STAGES + 1 + `INS_DEAD_CLOCKS + 1;
  endfunction
  task automatic check(input string s, input int e, input int g);
    check_count++;
    if (e !== g) begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", s, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_start(input int n);
    int k;
    k = 0;
    while (nS < n && k < 100) begin
      @(negedge mclk);
      k++;
    end
    check("starts", n, nS);
    check("latency", 1, k <= lat_max());
  endtask
  task automatic ret_pulse();
    @(posedge mclk) ret <= 1'b1;
    @(posedge mclk) ret <= 1'b0;
  endtask
  always @(posedge mclk) begin
    cyc++;
    bnd <= bEn && gap == 1;
    gap <= gap == 1 ? 1 + $urandom % 8 : gap - 1;
    if (start === 1'b1) begin
      nS++;
      nN += (isNmi === 1'b1);
    end
    if (cyc > 5000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(14));
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    SRC.set_maskable_irq_in(1'b1);
    repeat (30) @(negedge mclk);
    check("off", 0, nS);
    // Frozen unit must not accept although boundaries keep coming
    @(posedge mclk) begin
      intEn <= 1'b1;
      ce    <= 1'b0;
    end
    repeat (20) @(negedge mclk);
    check("frozen", 0, nS);
    @(posedge mclk) ce <= 1'b1;
    wait_start(1);
    check("nmi", 0, nN);
    SRC.nmi_pulse(1 + $urandom % 30);
    wait_start(2);
    repeat (30) @(negedge mclk);
    check("long", 2, nS);
    check("mask", 1, masked === 1'b1);
    SRC.nmi_pulse(1);
    SRC.nmi_pulse(2);
    repeat (30) @(negedge mclk);
    check("masked", 2, nS);
    ret_pulse();
    wait_start(3);
    repeat (30) @(negedge mclk);
    check("one pend", 3, nS);
    ret_pulse();
    // Boundaries held off so both requests meet one boundary
    @(posedge mclk) bEn <= 1'b0;
    fork
      SRC.set_maskable_irq_in(1'b1);
      SRC.nmi_pulse(3);
    join
    @(posedge mclk) bEn <= 1'b1;
    wait_start(4);
    check("first", 3, nN);
    wait_start(5);
    check("second", 3, nN);
    // One-clock maskable pulse with no boundary in reach must be lost
    @(posedge mclk) bEn <= 1'b0;
    SRC.set_maskable_irq_in(1'b1);
    SRC.set_maskable_irq_in(1'b0);
    repeat (4) @(posedge mclk);
    bEn <= 1'b1;
    repeat (30) @(negedge mclk);
    check("withdrawn", 5, nS);
    end_sim();
  end
endmodule
bind ins_front_end ins_front_end_checker u_chk (.mclk, .arst_n, .clkEn, .intEnable, .instrBoundary,
  .interrupt_return_instr, .holdNextInstr, .serviceStart, .serviceIsNmi, .nmiMaskedOut);
